// [src/periph_io_map.svh]
// Port addresses, field positions, reset values and timing counts of the I/O decoder.
`ifndef PERIPH_IO_MAP_SVH
`define PERIPH_IO_MAP_SVH

// ----------------------------------------------------------------------------
// Port addresses in processor I/O space
// ----------------------------------------------------------------------------
`define WATCHDOG_KICK_PORT_ADDR            8'h40
`define STATUS_LAMP_PORT_ADDR              8'h60
`define SERIAL_MEMORY_CLOCK_PORT_ADDR      8'h80
`define SERIAL_MEMORY_DATA_OUT_PORT_ADDR   8'ha0
`define EXPANSION_FIRST_READ_ADDR          8'hc0
`define EXPANSION_SECOND_READ_ADDR         8'hc2
`define EXPANSION_SPARE_READ_ADDR          8'hc4
`define EXPANSION_RESET_TRIGGER_ADDR       8'hc6
`define EXPANSION_ADDRESS_BYTE_FIRST_ADDR  8'hc8
`define EXPANSION_ADDRESS_BYTE_SECOND_ADDR 8'hca
`define EXPANSION_ADDRESS_BYTE_THIRD_ADDR  8'hcc
`define EXPANSION_WRITE_PORT_ADDR          8'hce
`define DISPLAY_CONTROL_PORT_ADDR          8'he0
`define DISPLAY_DATA_PORT_ADDR             8'he1

// ----------------------------------------------------------------------------
// Fields, reset values and timing
// ----------------------------------------------------------------------------
`define LATCH_BIT_POS                      7
`define LATCH_BIT_RESET                    1'h0
`define BYTE_RESET                         8'h00
`define UNMAPPED_READ_VALUE                8'h00
`define EXPANSION_RESET_CYCLES             4

`endif

// [src/periph_io_pkg.sv]
// Types shared by the I/O decoder, its far-side model and its testbench.
package periph_io_pkg;

	// ------------------------------------------------------------------------
	// Request from the host I/O bus
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} io_req_type;

	// ------------------------------------------------------------------------
	// Expansion bus outputs
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [23:0] addr;
		logic [2:0]  addr_stb;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
		logic [1:0]  rd_sel;
		logic        reset;
	} exp_bus_type;

	// ------------------------------------------------------------------------
	// Display controller outputs
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic       rs;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} disp_bus_type;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXP_READ,
		ST_DISP_READ
	} rd_state_type;

endpackage

// [src/pin_sync3.sv]
// Three-flop pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps
module pin_sync3
(
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic pin_i,
	output logic      level_o
);
	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic       level_q;
	logic       level_d;

	// ------------------------------------------------------------------------
	// Next values
	// ------------------------------------------------------------------------
	// Only the second stage reads the first one, so metastability stays put.
	always_comb
	begin
		stage_d = {stage_q[1:0], pin_i};
		level_d = level_q;
		if (stage_q[1] == stage_q[2])
		begin
			level_d = stage_q[2];
		end
	end

	// Registers freeze while the clock enable is low.
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			stage_q <= 3'h0;
			level_q <= 1'h0;
		end
		else if (ce_i)
		begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end

	assign level_o = level_q;
endmodule // pin_sync3

// [src/pulse_stretch.sv]
// Stretches a one-cycle trigger into a pulse of a fixed number of cycles.
`timescale 1ns/100ps
module pulse_stretch
#(
	parameter int unsigned CYCLES = 4
)
(
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic trig_i,
	output logic      pulse_o
);
	localparam int unsigned CW = $clog2(CYCLES + 1);

	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;
	logic          pulse_q;
	logic          pulse_d;

	// A pulse of zero cycles would never reach the far side.
	if (CYCLES < 1)
	begin : g_bad_cycles
		$error("pulse_stretch: CYCLES must be at least 1.");
	end

	// ------------------------------------------------------------------------
	// Next values
	// ------------------------------------------------------------------------
	// A new trigger restarts the count, so back-to-back triggers lengthen it.
	always_comb
	begin
		count_d = count_q;
		if (trig_i)
		begin
			count_d = CW'(CYCLES);
		end
		else if (count_q != '0)
		begin
			count_d = count_q - CW'(1);
		end
		pulse_d = (count_d != '0);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			count_q <= '0;
			pulse_q <= 1'h0;
		end
		else if (ce_i)
		begin
			count_q <= count_d;
			pulse_q <= pulse_d;
		end
	end

	assign pulse_o = pulse_q;
endmodule // pulse_stretch

// [src/board_peripheral_io_decoder.sv]
// Board-level decoder for the processor's external I/O ports.
`timescale 1ns/100ps
`include "periph_io_map.svh"

// Function
// - Write to watchdog port with bit 7 kicks watchdog only if jumper enables.
// - Status lamp follows bit 7 written to the lamp port.
// - Serial memory clock line holds the level written in bit 7.
// - Serial memory data line drives the value written in bit 7.
// - Three read ports return a full byte from the expansion bus.
// - Any read of the reset port resets expansion devices; data meaningless.
// - Three write ports present address bytes one, two, three to expansion bus.
// - Write port transfers the full byte onto the expansion bus.
// - Two ports give read and write access to display control and data.
module board_peripheral_io_decoder
#(
	parameter int unsigned EXP_RESET_CYCLES = `EXPANSION_RESET_CYCLES
)
(
	input  wire logic                       clk_sys_i,
	input  wire logic                       rst_i,
	input  wire logic                       ce_i,
	input  wire periph_io_pkg::io_req_type  io_req_i,
	output logic [7:0]                      io_rdata_o,
	output logic                            io_rvalid_o,
	input  wire logic                       kick_path_jumper_i,
	output logic                            watchdog_kick_o,
	output logic                            status_lamp_o,
	output logic                            mem_clock_o,
	output logic                            mem_data_o,
	output periph_io_pkg::exp_bus_type      exp_o,
	input  wire logic [7:0]                 exp_rdata_i,
	output periph_io_pkg::disp_bus_type     disp_o,
	input  wire logic [7:0]                 disp_rdata_i
);
	import periph_io_pkg::*;

	if (EXP_RESET_CYCLES < 1)
	begin : g_bad_reset_cycles
		$error("board_peripheral_io_decoder: EXP_RESET_CYCLES must be at least 1.");
	end

	// ------------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------------
	logic hit_kick;
	logic hit_lamp;
	logic hit_clock;
	logic hit_data;
	logic hit_exp_rd;
	logic hit_exp_rst;
	logic hit_disp;
	logic [1:0] exp_rd_sel;
	logic [2:0] addr_stb;
	logic hit_exp_wr;
	logic jumper_level;
	logic exp_reset_pulse;
	logic wr_ok;
	logic rd_ok;

	rd_state_type state_q;
	rd_state_type state_d;

	// Requests are only served while idle; a read in flight refuses others.
	assign wr_ok = io_req_i.wr && (state_q == ST_IDLE);
	assign rd_ok = io_req_i.rd && !io_req_i.wr && (state_q == ST_IDLE);

	// Decode each port address into a one-hot hit.
	always_comb
	begin
		hit_kick    = 1'b0;
		hit_lamp    = 1'b0;
		hit_clock   = 1'b0;
		hit_data    = 1'b0;
		hit_exp_rd  = 1'b0;
		hit_exp_rst = 1'b0;
		hit_disp    = 1'b0;
		hit_exp_wr  = 1'b0;
		exp_rd_sel  = 2'h0;
		addr_stb    = 3'h0;
		if (io_req_i.addr == `WATCHDOG_KICK_PORT_ADDR)
		begin
			hit_kick = 1'b1;
		end
		else if (io_req_i.addr == `STATUS_LAMP_PORT_ADDR)
		begin
			hit_lamp = 1'b1;
		end
		else if (io_req_i.addr == `SERIAL_MEMORY_CLOCK_PORT_ADDR)
		begin
			hit_clock = 1'b1;
		end
		else if (io_req_i.addr == `SERIAL_MEMORY_DATA_OUT_PORT_ADDR)
		begin
			hit_data = 1'b1;
		end
		else if ((io_req_i.addr == `EXPANSION_FIRST_READ_ADDR) ||
			(io_req_i.addr == `EXPANSION_SECOND_READ_ADDR) ||
			(io_req_i.addr == `EXPANSION_SPARE_READ_ADDR))
		begin
			hit_exp_rd = 1'b1;
			exp_rd_sel = io_req_i.addr[2:1]; // The read ports sit two apart.
		end
		else if (io_req_i.addr == `EXPANSION_RESET_TRIGGER_ADDR)
		begin
			hit_exp_rst = 1'b1;
		end
		else if ((io_req_i.addr == `EXPANSION_ADDRESS_BYTE_FIRST_ADDR) ||
			(io_req_i.addr == `EXPANSION_ADDRESS_BYTE_SECOND_ADDR) ||
			(io_req_i.addr == `EXPANSION_ADDRESS_BYTE_THIRD_ADDR))
		begin
			addr_stb = 3'h1 << io_req_i.addr[2:1]; // One lane per address byte.
		end
		else if (io_req_i.addr == `EXPANSION_WRITE_PORT_ADDR)
		begin
			hit_exp_wr = 1'b1;
		end
		else if ((io_req_i.addr == `DISPLAY_CONTROL_PORT_ADDR) ||
			(io_req_i.addr == `DISPLAY_DATA_PORT_ADDR))
		begin
			hit_disp = 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	// The jumper is a board pin, so it is synchronised before use.
	pin_sync3 u_jumper_sync
	(
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.pin_i     (kick_path_jumper_i),
		.level_o   (jumper_level)
	);

	// The expansion reset is held several cycles so slow devices see it.
	pulse_stretch #(.CYCLES(EXP_RESET_CYCLES)) u_exp_reset
	(
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.trig_i    (rd_ok && hit_exp_rst),
		.pulse_o   (exp_reset_pulse)
	);

	// ------------------------------------------------------------------------
	// Output latches and strobes
	// ------------------------------------------------------------------------
	logic        kick_q, kick_d;
	logic        lamp_q, lamp_d;
	logic        clock_q, clock_d;
	logic        data_q, data_d;
	exp_bus_type exp_q, exp_d;
	disp_bus_type disp_q, disp_d;
	logic [7:0]  rdata_q, rdata_d;
	logic        rvalid_q, rvalid_d;

	// Strobes last one cycle; latches change only on a write to their port, rs and rd_sel also on a read.
	always_comb
	begin
		kick_d         = 1'b0;
		lamp_d         = lamp_q;
		clock_d        = clock_q;
		data_d         = data_q;
		exp_d          = exp_q;
		exp_d.addr_stb = 3'h0;
		exp_d.wr       = 1'b0;
		exp_d.rd       = 1'b0;
		exp_d.reset    = exp_reset_pulse;
		disp_d         = disp_q;
		disp_d.wr      = 1'b0;
		disp_d.rd      = 1'b0;
		rdata_d        = rdata_q;
		rvalid_d       = 1'b0;
		state_d        = state_q;
		if (wr_ok)
		begin
			kick_d = hit_kick && jumper_level && io_req_i.wdata[`LATCH_BIT_POS];
			if (hit_lamp)
			begin
				lamp_d = io_req_i.wdata[`LATCH_BIT_POS];
			end
			if (hit_clock)
			begin
				clock_d = io_req_i.wdata[`LATCH_BIT_POS];
			end
			if (hit_data)
			begin
				data_d = io_req_i.wdata[`LATCH_BIT_POS];
			end
			// Each address byte lands in its own lane of the address.
			for (int i = 0; i < 3; i++)
			begin
				if (addr_stb[i])
				begin
					exp_d.addr[8*i +: 8] = io_req_i.wdata;
				end
			end
			exp_d.addr_stb = addr_stb;
			if (hit_exp_wr)
			begin
				exp_d.wdata = io_req_i.wdata;
				exp_d.wr    = 1'b1;
			end
			if (hit_disp)
			begin
				disp_d.rs    = io_req_i.addr[0];
				disp_d.wdata = io_req_i.wdata;
				disp_d.wr    = 1'b1;
			end
		end
		else if (rd_ok)
		begin
			if (hit_exp_rd)
			begin
				exp_d.rd     = 1'b1;
				exp_d.rd_sel = exp_rd_sel;
				state_d      = ST_EXP_READ;
			end
			else if (hit_disp)
			begin
				disp_d.rs = io_req_i.addr[0];
				disp_d.rd = 1'b1;
				state_d   = ST_DISP_READ;
			end
			else
			begin
				// Reset port and unmapped addresses answer a fixed value.
				rdata_d  = `UNMAPPED_READ_VALUE;
				rvalid_d = 1'b1;
			end
		end
		else
		begin
			case (state_q)
				ST_EXP_READ:
				begin
					rdata_d  = exp_rdata_i;
					rvalid_d = 1'b1;
					state_d  = ST_IDLE;
				end
				ST_DISP_READ:
				begin
					rdata_d  = disp_rdata_i;
					rvalid_d = 1'b1;
					state_d  = ST_IDLE;
				end
				default:
				begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	// All state freezes while the clock enable is low.
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			kick_q   <= 1'b0;
			lamp_q   <= `LATCH_BIT_RESET;
			clock_q  <= `LATCH_BIT_RESET;
			data_q   <= `LATCH_BIT_RESET;
			exp_q    <= '0;
			disp_q   <= '0;
			rdata_q  <= `BYTE_RESET;
			rvalid_q <= 1'b0;
			state_q  <= ST_IDLE;
		end
		else if (ce_i)
		begin
			kick_q   <= kick_d;
			lamp_q   <= lamp_d;
			clock_q  <= clock_d;
			data_q   <= data_d;
			exp_q    <= exp_d;
			disp_q   <= disp_d;
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
			state_q  <= state_d;
		end
	end

	assign watchdog_kick_o = kick_q;
	assign status_lamp_o   = lamp_q;
	assign mem_clock_o     = clock_q;
	assign mem_data_o      = data_q;
	assign exp_o           = exp_q;
	assign disp_o          = disp_q;
	assign io_rdata_o      = rdata_q;
	assign io_rvalid_o     = rvalid_q;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	kick_gated_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		watchdog_kick_o && $past(ce_i) |->
		$past(wr_ok && hit_kick && jumper_level && io_req_i.wdata[7]))
		else $error("Watchdog kick without jumper or bit 7.");
	lamp_follows_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && wr_ok && hit_lamp |=> status_lamp_o == $past(io_req_i.wdata[7]))
		else $error("Lamp does not follow bit 7.");
	mem_clock_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && wr_ok && hit_clock |=> mem_clock_o == $past(io_req_i.wdata[7]))
		else $error("Memory clock level wrong.");
	mem_data_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && wr_ok && hit_data |=> mem_data_o == $past(io_req_i.wdata[7]))
		else $error("Memory data level wrong.");
	exp_read_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && state_q == ST_EXP_READ |=> io_rvalid_o && io_rdata_o == $past(exp_rdata_i))
		else $error("Expansion read data not returned.");
	exp_reset_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && rd_ok && hit_exp_rst ##1 ce_i |=> exp_o.reset)
		else $error("Expansion reset not raised.");
	exp_addr_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && wr_ok && addr_stb == 3'h2 |=> exp_o.addr[15:8] == $past(io_req_i.wdata)
		&& exp_o.addr_stb == 3'h2)
		else $error("Second address byte not presented.");
	exp_write_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		exp_o.wr && $past(ce_i) |-> exp_o.wdata == $past(io_req_i.wdata) && $past(wr_ok && hit_exp_wr))
		else $error("Expansion write byte wrong.");
	disp_access_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && rd_ok && hit_disp ##1 ce_i |-> disp_o.rd && disp_o.rs == $past(io_req_i.addr[0])
		##1 io_rvalid_o)
		else $error("Display read access wrong.");
	latch_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!$past(wr_ok && hit_lamp) && !$past(rst_i) |-> $stable(status_lamp_o))
		else $error("Lamp latch changed without a write.");

endmodule // board_peripheral_io_decoder

// [dv/far_side_model.sv]
// Behavioural expansion bus devices and display controller facing the decoder.
`timescale 1ns/100ps
module far_side_model
(
	input  wire logic                        clk_sys_i,
	input  wire logic                        rst_i,
	input  wire periph_io_pkg::exp_bus_type  exp_i,
	output logic [7:0]                       exp_rdata_o,
	input  wire periph_io_pkg::disp_bus_type disp_i,
	output logic [7:0]                       disp_rdata_o
);
	import periph_io_pkg::*;
	logic [7:0] ctrl_q;
	logic [7:0] data_q;
	logic [7:0] noise_q;

	// ------------------------------------------------------------------------
	// Display registers and idle bus noise
	// ------------------------------------------------------------------------
	// Released lines change every cycle, so a sample taken late never matches.
	always_ff @(posedge clk_sys_i)
	begin
		noise_q <= rst_i ? 8'h5a : noise_q + 8'h3b;
		if (disp_i.wr && !disp_i.rs)
			ctrl_q <= disp_i.wdata;
		if (disp_i.wr && disp_i.rs)
			data_q <= disp_i.wdata;
	end

	// Devices answer only while the strobe is high, with a mix of address and select.
	always_comb
	begin
		exp_rdata_o  = exp_i.rd ? (exp_i.addr[7:0] ^ exp_i.addr[15:8] ^ exp_i.addr[23:16])
			+ {6'h00, exp_i.rd_sel} : noise_q;
		disp_rdata_o = !disp_i.rd ? noise_q : (disp_i.rs ? data_q : ctrl_q);
	end
endmodule // far_side_model

// [dv/tb_board_peripheral_io_decoder.sv]
// Self-checking testbench for the board I/O decoder.
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH t=%0t got %h expected %h", $time, (g), (e)); end end
module tb_board_peripheral_io_decoder;
	import periph_io_pkg::*;
	localparam int unsigned RST_CYC = 3;
	logic         clk_sys_i = 1'b0;
	logic         rst_i;
	logic         ce_i;
	io_req_type   req;
	logic [7:0]   io_rdata;
	logic         io_rvalid;
	logic         jumper;
	logic         kick;
	logic         lamp;
	logic         mclk;
	logic         mdat;
	exp_bus_type  exp_bus;
	logic [7:0]   exp_rdata;
	disp_bus_type disp_bus;
	logic [7:0]   disp_rdata;
	int           fails;
	int           tests_run;
	int           seed = 60;
	int           k;
	int           lat;
	logic [7:0]   d;
	logic [7:0]   r;
	logic [7:0]   dexp [2];
	logic [2:0]   lat_e;
	logic [23:0]  eaddr;
	logic [7:0]   ports [4] = '{8'h60, 8'h80, 8'ha0, 8'h42};

	// Clock of 50 ns period.
	always #25 clk_sys_i = ~clk_sys_i;

	board_peripheral_io_decoder #(.EXP_RESET_CYCLES(RST_CYC)) u_board_peripheral_io_decoder
	(
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .io_req_i(req),
		.io_rdata_o(io_rdata), .io_rvalid_o(io_rvalid), .kick_path_jumper_i(jumper),
		.watchdog_kick_o(kick), .status_lamp_o(lamp), .mem_clock_o(mclk),
		.mem_data_o(mdat), .exp_o(exp_bus), .exp_rdata_i(exp_rdata),
		.disp_o(disp_bus), .disp_rdata_i(disp_rdata)
	);

	far_side_model u_far_side_model
	(
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .exp_i(exp_bus),
		.exp_rdata_o(exp_rdata), .disp_i(disp_bus), .disp_rdata_o(disp_rdata)
	);

	// ------------------------------------------------------------------------
	// Bus tasks and expectations
	// ------------------------------------------------------------------------
	// Expected expansion read byte, written apart from the model on purpose.
	function automatic logic [7:0] exp_val(input logic [23:0] a, input logic [1:0] s);
		return (a[23:16] ^ a[15:8] ^ a[7:0]) + {6'h00, s};
	endfunction

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One-cycle write; returns in the cycle where its effect shows.
	task automatic wr_io(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk_sys_i);
		req.addr  = a;
		req.wdata = v;
		req.wr    = 1'b1;
		@(negedge clk_sys_i);
		req.wr = 1'b0;
	endtask

	// Read; waits a bounded number of cycles for the valid pulse.
	task automatic rd_io(input logic [7:0] a, output logic [7:0] v, output int n);
		@(negedge clk_sys_i);
		req.addr = a;
		req.rd   = 1'b1;
		@(negedge clk_sys_i);
		req.rd = 1'b0;
		n = 0;
		while (io_rvalid !== 1'b1 && n < 4)
		begin
			@(negedge clk_sys_i);
			n++;
		end
		if (n == 4)
		begin
			fails++;
			summarize();
		end
		v = io_rdata;
	endtask

	// ------------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------------
	initial
	begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		req = '0;
		jumper = 1'b0;
		fails = 0;
		tests_run = 0;
		lat_e = 3'h0;
		eaddr = 24'h000000;
		repeat (8) @(negedge clk_sys_i);
		rst_i = 1'b0;
		`CHK({kick, lamp, mclk, mdat, io_rvalid}, 5'h00)
		`CHK(exp_bus, '0)
		// The kick path is closed while the jumper is low.
		wr_io(8'h40, 8'h80);
		`CHK(kick, 1'b0)
		jumper = 1'b1;
		repeat (8) @(negedge clk_sys_i);
		wr_io(8'h40, 8'h80);
		`CHK(kick, 1'b1)
		@(negedge clk_sys_i);
		`CHK(kick, 1'b0)
		wr_io(8'h40, 8'h7f);
		`CHK(kick, 1'b0)
		// Random latch writes, with an unmapped port mixed in.
		for (int i = 0; i < 24; i++)
		begin
			k = {$random(seed)} % 4;
			d = 8'($random(seed));
			wr_io(ports[k], d);
			if (k < 3)
				lat_e[2 - k] = d[7];
			`CHK({lamp, mclk, mdat}, lat_e)
		end
		// A write with the clock enable low is not taken.
		ce_i = 1'b0;
		wr_io(8'h60, {~lat_e[2], 7'h00});
		ce_i = 1'b1;
		`CHK(lamp, lat_e[2])
		// Address, data and read rounds with random bytes.
		for (int i = 0; i < 4; i++)
		begin
			for (int j = 0; j < 3; j++)
			begin
				d = 8'($random(seed));
				wr_io(8'hc8 + 8'(2 * j), d);
				eaddr[8 * j +: 8] = d;
				`CHK(exp_bus.addr_stb, 3'b001 << j)
				`CHK(exp_bus.addr, eaddr)
			end
			d = 8'($random(seed));
			wr_io(8'hce, d);
			`CHK({exp_bus.wr, exp_bus.wdata}, {1'b1, d})
			for (int j = 0; j < 3; j++)
			begin
				rd_io(8'hc0 + 8'(2 * j), r, lat);
				`CHK(r, exp_val(eaddr, 2'(j)))
				`CHK(lat, 1)
			end
		end
		// Writes to a read-only port and reads of write-only or unmapped ports.
		wr_io(8'hc0, 8'hff);
		`CHK({exp_bus.addr_stb, exp_bus.wr, exp_bus.addr}, {4'h0, eaddr})
		rd_io(8'h60, r, lat);
		`CHK(r, 8'h00)
		rd_io(8'h50, r, lat);
		`CHK(r, 8'h00)
		// The reset read answers at once, then the reset pulse follows.
		rd_io(8'hc6, r, lat);
		`CHK(lat, 0)
		k = 0;
		@(negedge clk_sys_i);
		while (exp_bus.reset === 1'b1 && k < 20)
		begin
			k++;
			@(negedge clk_sys_i);
		end
		`CHK(k, RST_CYC)
		// Display registers are written and read back independently.
		for (int i = 0; i < 3; i++)
		begin
			for (int j = 0; j < 2; j++)
			begin
				dexp[j] = 8'($random(seed));
				wr_io(8'he0 + 8'(j), dexp[j]);
				`CHK({disp_bus.wr, disp_bus.rs, disp_bus.wdata}, {1'b1, j[0], dexp[j]})
			end
			for (int j = 0; j < 2; j++)
			begin
				rd_io(8'he0 + 8'(j), r, lat);
				`CHK(r, dexp[j])
			end
		end
		// A reset in mid-run clears the latches.
		wr_io(8'h60, 8'h80);
		wr_io(8'h80, 8'h80);
		wr_io(8'ha0, 8'h80);
		`CHK({lamp, mclk, mdat}, 3'h7)
		rst_i = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		rst_i = 1'b0;
		`CHK({lamp, mclk, mdat}, 3'h0)
		`CHK(exp_bus, '0)
		// The first write after a reset in mid-run is taken normally.
		wr_io(8'h60, 8'h80);
		`CHK(lamp, 1'b1)
		summarize();
	end
endmodule // tb_board_peripheral_io_decoder
